// ---- inc/tpo_pkg.sv ----
// Constants, register map and channel carrier of the pulse timer unit.
package tpo_pkg;
   localparam int ADDR_W = 18;
   localparam int IDX_W = 16;
   // Word indexes; the byte address is four times the index.
   localparam logic [15:0] IDX_START = 16'hfe70;
   localparam logic [15:0] IDX_NEXT_EN_HI = 16'hfe71;
   localparam logic [15:0] IDX_NEXT_EN_LO = 16'hfe72;
   localparam logic [15:0] IDX_NEXT_DATA = 16'hfe73;
   localparam logic [15:0] IDX_OUT_DATA = 16'hfe74;
   localparam logic [15:0] IDX_TRIG_SEL = 16'hfe75;
   localparam logic [15:0] IDX_IRQ_STAT = 16'hfe76;
   localparam logic [15:0] IDX_IRQ_MASK = 16'hfe77;
   localparam logic [15:0] IDX_MODE3 = 16'hfe81;
   localparam logic [15:0] IDX_CH_BASE = 16'hfe90;
   localparam int CH_STRIDE = 8;
   // Word offsets inside one channel block.
   localparam logic [2:0] CR_CTRL = 3'h0;
   localparam logic [2:0] CR_IEN = 3'h1;
   localparam logic [2:0] CR_STAT = 3'h2;
   localparam logic [2:0] CR_COUNT = 3'h3;
   localparam logic [2:0] CR_CMPA = 3'h4;
   localparam logic [2:0] CR_CMPB = 3'h5;
   localparam logic [2:0] CR_CMPD = 3'h6;
   // Control register fields.
   localparam int CKS_LSB = 0;
   localparam int CCLR_LSB = 5;
   localparam logic [2:0] CCLR_FREE = 3'h0;
   localparam logic [2:0] CCLR_CMPA = 3'h1;
   localparam logic [2:0] CCLR_CMPB = 3'h2;
   // Flag and enable positions, shared by status and interrupt enable.
   localparam int FLG_A = 0;
   localparam int FLG_B = 1;
   localparam int FLG_OVF = 4;
   localparam int MODE3_BUF_B = 4;
   localparam int TRIG_HI_LSB = 0;
   localparam int TRIG_LO_LSB = 4;
   localparam int BUF_CH = 3;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] ien;
      logic [7:0] stat;
      logic [7:0] armed;
      logic [5:0] pre;
      logic ticked;
      logic [15:0] count;
      logic [15:0] cmpA;
      logic [15:0] cmpB;
   } tpo_chan_t;
   localparam tpo_chan_t CHAN_RST = '{default: '0};
endpackage : tpo_pkg

// ---- src/tpo_timer.sv ----
// Timer channels, pulse output next-data logic and APB register slave.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - After reset every counter is free running, with no clearing source selected.
// - A counter counts up only while its bit in the counter start register is 1.
// - A wrap from the maximum count to zero sets the channel overflow flag.
// - An overflow flag set while its enable bit is 1 raises an interrupt request.
// - After an overflow the counter keeps counting up from zero.
// - Compare-match clearing selected in the control register gives periodic counting.
// - In periodic mode a count equal to the compare register sets the flag and clears it.
// - A compare flag set while its enable bit is 1 raises an interrupt request.
// - After a compare clear the counter counts up again from zero.
// - Buffer bit 0 leaves compare register B alone; 1 reloads it from D.
// - An enabled pulse bit takes its staged next-data bit on the selected match.
// - A disabled pulse bit is not transferred and its output stays unchanged.
// - The high enable register covers outputs 15 to 8, the low one 7 to 0.
// - Reset and hardware standby clear both enable registers; software standby keeps them.
module tpo_timer
   import tpo_pkg::*;
#(
   parameter int NCH = 4
) (
   input wire logic clk, // System clock.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic ce, // Clock enable; state freezes while low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [ADDR_W-1:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic hwStandbyPin, // Hardware standby request pin.
   input wire logic swStandbyPin, // Software standby request pin.
   output logic [15:0] pulseOut, // Pulse output pins.
   output logic [NCH-1:0] chanIrq, // Per channel interrupt requests.
   output logic irq // Combined masked interrupt.
);
   localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;
   localparam int EW = 2 * NCH;

   tpo_chan_t chan_q [NCH];
   tpo_chan_t chan_d [NCH];
   logic [NCH-1:0] start_q, start_d;
   logic [7:0] nextEnHi_q, nextEnHi_d;
   logic [7:0] nextEnLo_q, nextEnLo_d;
   logic [15:0] nextData_q, nextData_d;
   logic [15:0] outData_q, outData_d;
   logic [7:0] trigSel_q, trigSel_d;
   logic [7:0] mode3_q, mode3_d;
   logic [15:0] cmpD_q, cmpD_d;
   logic [EW-1:0] irqStat_q, irqStat_d;
   logic [EW-1:0] irqMask_q, irqMask_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] hwSync_q, swSync_q;

   logic [NCH-1:0] tick, matchA, matchB, ovf;
   logic [EW-1:0] events;
   logic [IDX_W-1:0] idx, chOff;
   logic [CW-1:0] chSel;
   logic [2:0] chReg;
   logic inCh, hit, acc, wr, rd, setup;
   logic hwStby, swStby;

   // Only the second stage of each synchroniser is looked at.
   assign hwStby = hwSync_q[1];
   assign swStby = swSync_q[1];

   assign idx = paddr[ADDR_W-1:2];
   assign chOff = idx - IDX_CH_BASE;
   assign chSel = chOff[CW+2:3];
   assign chReg = chOff[2:0];
   assign inCh = (idx >= IDX_CH_BASE) && (chOff < IDX_W'(NCH * CH_STRIDE));
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign setup = psel && !penable;

   // Zero wait states: read data is captured in the setup phase.
   assign pready = 1'b1;
   assign pslverr = acc && !hit;
   assign prdata = rdata_q;
   assign pulseOut = outData_q;

   function automatic logic [5:0] preMask(input logic [1:0] cks);
      case (cks)
         2'h0: preMask = 6'h00;
         2'h1: preMask = 6'h03;
         2'h2: preMask = 6'h0f;
         default: preMask = 6'h3f;
      endcase
   endfunction : preMask

   always_comb begin
      hit = 1'b0;
      rdata_d = rdata_q;
      if (inCh) begin
         hit = (chReg <= CR_CMPB) || (chReg == CR_CMPD && 32'(chSel) == BUF_CH);
      end else begin
         case (idx)
            IDX_START, IDX_NEXT_EN_HI, IDX_NEXT_EN_LO, IDX_NEXT_DATA,
            IDX_OUT_DATA, IDX_TRIG_SEL, IDX_IRQ_STAT, IDX_IRQ_MASK,
            IDX_MODE3: hit = 1'b1;
            default: hit = 1'b0;
         endcase
      end
      if (setup) begin
         rdata_d = '0;
         if (inCh) begin
            case (chReg)
               CR_CTRL: rdata_d[7:0] = chan_q[chSel].ctrl;
               CR_IEN: rdata_d[7:0] = chan_q[chSel].ien;
               CR_STAT: rdata_d[7:0] = chan_q[chSel].stat;
               CR_COUNT: rdata_d[15:0] = chan_q[chSel].count;
               CR_CMPA: rdata_d[15:0] = chan_q[chSel].cmpA;
               CR_CMPB: rdata_d[15:0] = chan_q[chSel].cmpB;
               CR_CMPD: rdata_d[15:0] = cmpD_q;
               default: rdata_d = '0;
            endcase
         end else begin
            case (idx)
               IDX_START: rdata_d[NCH-1:0] = start_q;
               IDX_NEXT_EN_HI: rdata_d[7:0] = nextEnHi_q;
               IDX_NEXT_EN_LO: rdata_d[7:0] = nextEnLo_q;
               IDX_NEXT_DATA: rdata_d[15:0] = nextData_q;
               IDX_OUT_DATA: rdata_d[15:0] = outData_q;
               IDX_TRIG_SEL: rdata_d[7:0] = trigSel_q;
               IDX_IRQ_STAT: rdata_d[EW-1:0] = irqStat_q;
               IDX_IRQ_MASK: rdata_d[EW-1:0] = irqMask_q;
               IDX_MODE3: rdata_d[7:0] = mode3_q;
               default: rdata_d = '0;
            endcase
         end
      end
   end

   // Channel counters, flags and compare registers.
   always_comb begin
      chan_d = chan_q;
      cmpD_d = cmpD_q;
      tick = '0;
      matchA = '0;
      matchB = '0;
      ovf = '0;
      for (int c = 0; c < NCH; c++) begin
         // Prescaler stops with the counter and keeps its value, so a restart resumes the partial period.
         if (start_q[c] && !swStby) begin
            chan_d[c].pre = chan_q[c].pre + 6'h01;
            tick[c] = (chan_q[c].pre & preMask(chan_q[c].ctrl[CKS_LSB +: 2]))
               == preMask(chan_q[c].ctrl[CKS_LSB +: 2]);
         end
         chan_d[c].ticked = tick[c];
         // The compare sees the counter value taken on the previous tick.
         matchA[c] = chan_q[c].ticked && (chan_q[c].count == chan_q[c].cmpA);
         matchB[c] = chan_q[c].ticked && (chan_q[c].count == chan_q[c].cmpB);
         if (tick[c]) begin
            if ((chan_q[c].ctrl[CCLR_LSB +: 3] == CCLR_CMPA
                 && chan_q[c].count == chan_q[c].cmpA)
                || (chan_q[c].ctrl[CCLR_LSB +: 3] == CCLR_CMPB
                 && chan_q[c].count == chan_q[c].cmpB)) begin
               chan_d[c].count = RST_WORD;
            end else begin
               chan_d[c].count = chan_q[c].count + 16'h0001;
               ovf[c] = chan_q[c].count == CNT_MAX;
            end
         end
         if (c == BUF_CH && mode3_q[MODE3_BUF_B] && matchB[c]) begin
            chan_d[c].cmpB = cmpD_q;
         end
         if (rd && inCh && 32'(chSel) == c && chReg == CR_STAT) begin
            chan_d[c].armed = chan_q[c].stat;
         end
         if (wr && inCh && 32'(chSel) == c) begin
            case (chReg)
               CR_CTRL: chan_d[c].ctrl = pwdata[7:0];
               CR_IEN: chan_d[c].ien = pwdata[7:0];
               CR_STAT: begin
                  chan_d[c].stat = chan_q[c].stat
                     & ~(chan_q[c].armed & ~pwdata[7:0]);
                  chan_d[c].armed = RST_BYTE;
               end
               CR_COUNT: chan_d[c].count = pwdata[15:0];
               CR_CMPA: chan_d[c].cmpA = pwdata[15:0];
               CR_CMPB: chan_d[c].cmpB = pwdata[15:0];
               CR_CMPD: begin
                  if (c == BUF_CH) begin
                     cmpD_d = pwdata[15:0];
                  end
               end
               default: chan_d[c].ctrl = chan_d[c].ctrl;
            endcase
         end
         // Hardware setting wins over a software clear in the same cycle.
         if (ovf[c]) begin
            chan_d[c].stat[FLG_OVF] = 1'b1;
         end
         if (matchA[c]) begin
            chan_d[c].stat[FLG_A] = 1'b1;
         end
         if (matchB[c]) begin
            chan_d[c].stat[FLG_B] = 1'b1;
         end
      end
      if (hwStby) begin
         for (int c = 0; c < NCH; c++) begin
            chan_d[c] = CHAN_RST;
         end
         cmpD_d = RST_WORD;
      end
   end

   // Requests follow flag and enable as levels.
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         chanIrq[c] = |(chan_q[c].stat & chan_q[c].ien
            & ((8'h01 << FLG_A) | (8'h01 << FLG_B) | (8'h01 << FLG_OVF)));
         events[c] = matchA[c];
         events[NCH + c] = ovf[c];
      end
   end

   assign irq = |(irqStat_q & irqMask_q);

   // Global registers, pulse output data and interrupt status.
   always_comb begin
      start_d = start_q;
      nextEnHi_d = nextEnHi_q;
      nextEnLo_d = nextEnLo_q;
      nextData_d = nextData_q;
      outData_d = outData_q;
      trigSel_d = trigSel_q;
      mode3_d = mode3_q;
      irqMask_d = irqMask_q;
      irqStat_d = irqStat_q;
      if (rd && !inCh && idx == IDX_IRQ_STAT) begin
         irqStat_d = '0;
      end
      if (wr && !inCh) begin
         case (idx)
            IDX_START: start_d = pwdata[NCH-1:0];
            IDX_NEXT_EN_HI: nextEnHi_d = pwdata[7:0];
            IDX_NEXT_EN_LO: nextEnLo_d = pwdata[7:0];
            IDX_NEXT_DATA: nextData_d = pwdata[15:0];
            IDX_OUT_DATA: outData_d = pwdata[15:0];
            IDX_TRIG_SEL: trigSel_d = pwdata[7:0];
            IDX_IRQ_MASK: irqMask_d = pwdata[EW-1:0];
            IDX_MODE3: mode3_d = pwdata[7:0];
            default: start_d = start_q;
         endcase
      end
      // A match moves only the enabled bits; disabled bits hold their output.
      if (matchA[trigSel_q[TRIG_HI_LSB +: CW]]) begin
         outData_d[15:8] = (nextEnHi_q & nextData_q[15:8])
            | (~nextEnHi_q & outData_q[15:8]);
      end
      if (matchA[trigSel_q[TRIG_LO_LSB +: CW]]) begin
         outData_d[7:0] = (nextEnLo_q & nextData_q[7:0])
            | (~nextEnLo_q & outData_q[7:0]);
      end
      irqStat_d = irqStat_d | events;
      // Software standby leaves every register as it stands.
      if (hwStby) begin
         start_d = '0;
         nextEnHi_d = RST_BYTE;
         nextEnLo_d = RST_BYTE;
         nextData_d = RST_WORD;
         outData_d = RST_WORD;
         trigSel_d = RST_BYTE;
         mode3_d = RST_BYTE;
         irqMask_d = '0;
         irqStat_d = '0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int c = 0; c < NCH; c++) begin
            chan_q[c] <= CHAN_RST;
         end
         cmpD_q <= RST_WORD;
         start_q <= '0;
         nextEnHi_q <= RST_BYTE;
         nextEnLo_q <= RST_BYTE;
         nextData_q <= RST_WORD;
         outData_q <= RST_WORD;
         trigSel_q <= RST_BYTE;
         mode3_q <= RST_BYTE;
         irqMask_q <= '0;
         irqStat_q <= '0;
         rdata_q <= '0;
         hwSync_q <= '0;
         swSync_q <= '0;
      end else if (ce) begin
         chan_q <= chan_d;
         cmpD_q <= cmpD_d;
         start_q <= start_d;
         nextEnHi_q <= nextEnHi_d;
         nextEnLo_q <= nextEnLo_d;
         nextData_q <= nextData_d;
         outData_q <= outData_d;
         trigSel_q <= trigSel_d;
         mode3_q <= mode3_d;
         irqMask_q <= irqMask_d;
         irqStat_q <= irqStat_d;
         rdata_q <= rdata_d;
         hwSync_q <= {hwSync_q[0], hwStandbyPin};
         swSync_q <= {swSync_q[0], swStandbyPin};
      end
   end
endmodule : tpo_timer

`default_nettype wire

// ---- testbench/tpo_timer_checker.sv ----
// Port-level assertions for the pulse timer unit.
`timescale 1ns/1ps
`default_nettype none
module tpo_timer_checker
   import tpo_pkg::*;
#(
   parameter int NCH = 4
) (
   input wire logic clk, // System clock.
   input wire logic reset, // Asynchronous reset.
   input wire logic ce, // Clock enable.
   input wire logic psel, // Bus select.
   input wire logic penable, // Bus enable.
   input wire logic pwrite, // Bus direction.
   input wire logic [31:0] prdata, // Read data.
   input wire logic pready, // Ready.
   input wire logic pslverr, // Slave error.
   input wire logic hwStandbyPin, // Hardware standby.
   input wire logic swStandbyPin, // Software standby.
   input wire logic [15:0] pulseOut, // Pulse outputs.
   input wire logic [NCH-1:0] chanIrq, // Channel requests.
   input wire logic irq // Combined request.
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Standby pins pass a two-stage synchroniser, so a few samples are needed first.
   sequence hwHeld;
      hwStandbyPin [*4];
   endsequence
   sequence swHeld;
      swStandbyPin [*5] ##0 !psel;
   endsequence
   sequence accessPh;
      psel && penable;
   endsequence
   AST_PREADY: assert property (pready == 1'b1)
      else $error("ready not high");
   AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   AST_ERR_DATA: assert property (accessPh ##0 (pslverr && !pwrite) |-> prdata == 32'h0)
      else $error("refused read gave data");
   AST_RD_HOLD: assert property (!(psel && !penable) && !hwStandbyPin && !$past(hwStandbyPin)
      && !$past(hwStandbyPin, 2) |=> $stable(prdata))
      else $error("read data moved outside setup");
   AST_CE_FREEZE: assert property (!ce |=> $stable(pulseOut) && $stable(chanIrq))
      else $error("state moved with enable low");
   AST_RST_QUIET: assert property ($fell(reset) |->
      (pulseOut == 16'h0000 && irq == 1'b0 && chanIrq == '0) [*2])
      else $error("outputs active after reset");
   AST_HW_CLEAR: assert property (hwHeld |=> pulseOut == 16'h0000 && chanIrq == '0 && !irq)
      else $error("hardware standby did not clear");
   AST_SW_HOLD: assert property (swHeld |=> $stable(pulseOut) && $stable(chanIrq))
      else $error("software standby changed state");
endmodule : tpo_timer_checker
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench of the pulse timer unit.
`timescale 1ns/1ps
`default_nettype none
module tb
   import tpo_pkg::*;
;
   typedef struct {
      logic [15:0] idx;
      logic [31:0] wd;
      logic [31:0] ex;
      logic er;
   } tpo_row_t;
   logic clk, reset, ce, psel, penable, pwrite, pready, pslverr, e, irq;
   logic hwStandbyPin, swStandbyPin;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, d, a;
   logic [15:0] pulseOut;
   logic [3:0] chanIrq;
   int n_fail = 0;
   int checked = 0;
   tpo_row_t rows[7] = '{
      '{IDX_NEXT_EN_HI, 32'h0000_00ff, 32'h0000_00ff, 1'b0},
      '{IDX_NEXT_EN_LO, 32'h1234_5a5a, 32'h0000_005a, 1'b0},
      '{IDX_MODE3, 32'h0000_0010, 32'h0000_0010, 1'b0},
      '{IDX_OUT_DATA, 32'h0000_beef, 32'h0000_beef, 1'b0},
      '{IDX_CH_BASE + 16'h0004, 32'h0000_abcd, 32'h0000_abcd, 1'b0},
      '{16'h0001, 32'h0000_0077, 32'h0, 1'b1},
      '{IDX_CH_BASE + 16'h0007, 32'h0000_0077, 32'h0, 1'b1}};
   tpo_timer #(.NCH(4)) tpo_timer_inst (.clk, .reset, .ce, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .hwStandbyPin, .swStandbyPin, .pulseOut, .chanIrq,
      .irq);
   task automatic results;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] ex, input string m);
      checked++;
      if (got !== ex) begin
         n_fail++;
         $display("mismatch t=%0t %s got %h exp %h", $time, m, got, ex);
      end
   endtask : chk
   // Entered just after a rising edge; ends one idle edge later so strobes never clash.
   task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] wd);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 16) begin
         n_fail++;
         results();
      end
      @(posedge clk);
   endtask : bus
   task automatic waitIrq(input int b);
      int k;
      k = 0;
      while (chanIrq[b] !== 1'b1 && k < 300) begin
         @(posedge clk);
         k++;
      end
      if (k >= 300) begin
         n_fail++;
         results();
      end
   endtask : waitIrq
   function automatic logic [15:0] ch(input int c, input logic [2:0] o);
      return IDX_CH_BASE + 16'(c * CH_STRIDE) + 16'(o);
   endfunction : ch
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      reset = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 18'h0;
      pwdata = 32'h0;
      hwStandbyPin = 1'b0;
      swStandbyPin = 1'b0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      foreach (rows[r]) begin
         bus(1'b1, rows[r].idx, rows[r].wd);
         chk(32'(e), 32'(rows[r].er), "write error");
         bus(1'b0, rows[r].idx, 32'h0);
         chk(d, rows[r].ex, "readback");
         chk(32'(e), 32'(rows[r].er), "read error");
      end
      chk(32'(pulseOut), 32'h0000_beef, "output data");
      $display("register table done");
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk(32'(pulseOut), 32'h0, "pulse after reset");
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, i == 0 ? IDX_NEXT_EN_HI : i == 1 ? IDX_NEXT_EN_LO : i == 2 ? IDX_MODE3 :
            ch(0, i == 3 ? CR_CTRL : CR_COUNT), 32'h0);
         chk(d, 32'h0, "reset value");
      end
      $display("reset done");
      bus(1'b1, ch(0, CR_IEN), 32'h10);
      bus(1'b1, ch(0, CR_COUNT), 32'hfffd);
      bus(1'b1, IDX_IRQ_MASK, 32'h10);
      bus(1'b1, IDX_START, 32'h1);
      waitIrq(0);
      chk(32'(irq), 32'h1, "overflow irq");
      bus(1'b1, IDX_START, 32'h0);
      bus(1'b0, ch(0, CR_COUNT), 32'h0);
      chk(32'(d < 32'h20 && d != 32'h0), 32'h1, "count after wrap");
      bus(1'b1, ch(0, CR_STAT), 32'h0);
      chk(32'(chanIrq[0]), 32'h1, "unarmed clear");
      bus(1'b0, ch(0, CR_STAT), 32'h0);
      chk(d & 32'h10, 32'h10, "overflow flag");
      bus(1'b1, ch(0, CR_STAT), 32'h0);
      chk(32'(chanIrq[0]), 32'h0, "armed clear");
      bus(1'b1, IDX_IRQ_MASK, 32'h0);
      chk(32'(irq), 32'h0, "masked");
      bus(1'b1, IDX_IRQ_MASK, 32'h10);
      bus(1'b0, IDX_IRQ_STAT, 32'h0);
      chk(d & 32'h10, 32'h10, "irq status");
      chk(32'(irq), 32'h0, "read clears");
      $display("overflow done");
      for (int m = 0; m < 2; m++) begin
         // A match flag left over from the previous pass would end the wait at once.
         bus(1'b0, ch(3, CR_STAT), 32'h0);
         bus(1'b1, ch(3, CR_STAT), 32'h0);
         chk(32'(chanIrq[3]), 32'h0, "buffer flag cleared");
         bus(1'b1, IDX_MODE3, 32'(m * 16));
         bus(1'b1, ch(3, CR_CMPB), 32'h5);
         bus(1'b1, ch(3, CR_CMPD), 32'h9);
         bus(1'b1, ch(3, CR_IEN), 32'h2);
         bus(1'b1, ch(3, CR_CTRL), 32'h40);
         bus(1'b1, IDX_START, 32'h8);
         waitIrq(3);
         bus(1'b1, IDX_START, 32'h0);
         bus(1'b0, ch(3, CR_CMPB), 32'h0);
         chk(d, m == 1 ? 32'h9 : 32'h5, "buffer");
      end
      $display("buffer done");
      bus(1'b1, IDX_TRIG_SEL, 32'h11);
      bus(1'b1, IDX_NEXT_DATA, 32'ha5c3);
      bus(1'b1, IDX_NEXT_EN_HI, 32'hff);
      bus(1'b1, IDX_NEXT_EN_LO, 32'h0f);
      bus(1'b1, ch(1, CR_CTRL), 32'h20);
      bus(1'b1, ch(1, CR_CMPA), 32'h2);
      bus(1'b1, ch(1, CR_IEN), 32'h1);
      bus(1'b1, IDX_START, 32'h2);
      waitIrq(1);
      chk(32'(pulseOut), 32'ha503, "pulse transfer");
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, ch(1, CR_COUNT), 32'h0);
         chk(32'(d <= 32'h2), 32'h1, "period");
      end
      bus(1'b0, ch(1, CR_STAT), 32'h0);
      chk(d & 32'h1, 32'h1, "match flag");
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      swStandbyPin <= 1'b1;
      repeat (6) @(posedge clk);
      bus(1'b0, ch(1, CR_COUNT), 32'h0);
      a = d;
      bus(1'b0, ch(1, CR_COUNT), 32'h0);
      chk(d, a, "standby count");
      bus(1'b0, IDX_NEXT_EN_HI, 32'h0);
      chk(d, 32'hff, "standby keeps");
      swStandbyPin <= 1'b0;
      hwStandbyPin <= 1'b1;
      repeat (6) @(posedge clk);
      hwStandbyPin <= 1'b0;
      repeat (3) @(posedge clk);
      bus(1'b0, IDX_NEXT_EN_LO, 32'h0);
      chk(d, 32'h0, "standby clears");
      $display("pulse and standby done");
      results();
   end
endmodule : tb
bind tpo_timer tpo_timer_checker #(.NCH(NCH)) tpo_timer_checker_inst (.clk, .reset, .ce, .psel,
   .penable, .pwrite, .prdata, .pready, .pslverr, .hwStandbyPin, .swStandbyPin, .pulseOut,
   .chanIrq, .irq);
`default_nettype wire
